// ===== core/psm_ctrl.sv
// Purpose: Power save mode control with power control register
// Assumes: Enable pin and strobes synchronous to clk_sys
// Notes:   Power-down sequence beyond entry is outside this block
//
// What this block does
// - Enable pin high makes every power-save entry sequence harmless.
// - Watchdog starts at reset release only if enable pin was high.
// - Enable pin low allows all modes; watchdog waits for software.
// - Enable pin changes later gate entry only, never watchdog.
// - Enable pin level is sampled in state 3 phase 1.
// - Power-down wins when power-down and idle are both requested.
// - Power-down start bit is forced low while enable pin is high.
// - Arm bit enables a later start; start write is last instruction.
// - Clock-divide bit enables slow-down operation.
// - Idle gates CPU clock; peripherals except watchdog keep clock.
// - Watchdog is stopped for the whole idle period.
// - CPU state is preserved during idle.
// - Port pins hold state; active alternate outputs keep driving.
// - Address latch and program fetch strobes stay high in idle.
// - Halt arm and start in one write do not enter idle.
// - Halt bits self-clear and always read zero.
// - The halt-start write is the last instruction before idle.
// - Enabled interrupt ends idle; execution resumes after it.
// - Reset ends idle; two machine cycles give full reset.
// - Power-down arm and start in one write do not enter it.
// - Clock-divide divides by 8 within two machine cycles.
`timescale 1ns/100ps
module psm_ctrl
	import psm_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       clk_en,
	// Register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	// Pins and system
	input  wire logic       power_save_enable_pin,
	input  wire logic       irq_pending,
	input  wire logic       cpu_addr_latch,
	input  wire logic       cpu_program_fetch,
	input  wire logic [7:0] port_out,
	input  wire logic [7:0] port_alt_en,
	input  wire logic [7:0] port_alt_out,
	// Clock gating and status
	output logic            cpu_clk_en,
	output logic            periph_clk_en,
	output logic            watchdog_run_en,
	output logic            watchdog_auto_start,
	output logic            power_down_enter,
	output logic            idle_active,
	output logic            slow_active,
	// Pins during idle
	output logic            addr_latch_strobe,
	output logic            program_fetch_strobe,
	output logic [7:0]      port_pins
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic       pin_s1;
		logic       pin_s2;
		logic       pin_lvl;
		logic       rst_seen;
		logic       wd_auto;
		logic       halt_arm;
		logic       pd_arm;
		logic       clk_div;
		logic       flag_a;
		logic       flag_b;
		psm_mode_t  mode;
		logic [7:0] rdata;
		logic [7:0] port_hold;
		logic [7:0] pins;
		logic       ale;
		logic       fetch;
		logic       cpu_en;
		logic       per_en;
		logic       wd_en;
		logic       pd_out;
		logic       idle;
	} psm_state_t;

	psm_state_t s_q;
	psm_state_t s_d;

	logic       tick;
	logic [3:0] phase;
	logic       slow_now;

	psm_phase_gen u_phase
	(
		.clk_sys     (clk_sys),
		.rst         (rst),
		.clk_en      (clk_en),
		.slow_req    (s_q.clk_div),
		.phase_tick  (tick),
		.phase_idx   (phase),
		.slow_active (slow_now)
	);

	function automatic logic bit_of(input logic [7:0] v, input int pos);
		return v[pos];
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic       wr_pc;
	logic       blocked;
	logic       halt_go;
	logic       pd_go;
	logic [7:0] rd_val;

	always_comb
	begin
		s_d     = s_q;
		wr_pc   = reg_wr && (reg_addr == PSM_OFS_POWER_CONTROL);
		s_d.pin_s1 = power_save_enable_pin;
		s_d.pin_s2 = s_q.pin_s1;
		if (tick && (phase == PSM_S3P1))
			s_d.pin_lvl = s_q.pin_s2;
		// Capture strap right after release
		// Sync stages are cleared by reset, so the strap is the pin itself
		if (!s_q.rst_seen)
		begin
			s_d.rst_seen = 1'b1;
			// Pin low here leaves the watchdog to software
			s_d.wd_auto  = power_save_enable_pin;
		end
		blocked = s_q.pin_lvl;
		halt_go = 1'b0;
		pd_go   = 1'b0;
		// Arm bits are single-shot, cleared each write
		if (wr_pc)
		begin
			s_d.flag_a  = bit_of(reg_wdata, PSM_BIT_USER_FLAG_A);
			s_d.flag_b  = bit_of(reg_wdata, PSM_BIT_USER_FLAG_B);
			s_d.clk_div = bit_of(reg_wdata, PSM_BIT_CLOCK_DIVIDE);
			// Start only with a prior arm, arm not rewritten
			halt_go = s_q.halt_arm && !blocked
				&& bit_of(reg_wdata, PSM_BIT_HALT_START)
				&& !bit_of(reg_wdata, PSM_BIT_HALT_ARM);
			// Start bit forced low while pin high
			pd_go = s_q.pd_arm && !blocked
				&& bit_of(reg_wdata, PSM_BIT_PD_START)
				&& !bit_of(reg_wdata, PSM_BIT_PD_ARM);
			// Arm lasts until the next write
			s_d.halt_arm = bit_of(reg_wdata, PSM_BIT_HALT_ARM)
				&& !bit_of(reg_wdata, PSM_BIT_HALT_START) && !blocked;
			s_d.pd_arm = bit_of(reg_wdata, PSM_BIT_PD_ARM)
				&& !bit_of(reg_wdata, PSM_BIT_PD_START) && !blocked;
		end
		unique case (s_q.mode)
			PSM_RUN:
			begin
				// The start write itself completes first
				if (pd_go)
					s_d.mode = PSM_DOWN;
				else if (halt_go)
				begin
					s_d.mode      = PSM_IDLE;
					s_d.port_hold = port_out;
				end
			end
			PSM_IDLE:
			begin
				if (irq_pending)
					s_d.mode = PSM_RUN;
			end
			PSM_DOWN:
				s_d.mode = PSM_DOWN;
			default:
				s_d.mode = PSM_RUN;
		endcase
		// CPU clock gated in idle, peripherals keep theirs
		// Both follow the divided phase tick
		s_d.cpu_en = (s_d.mode == PSM_RUN) && tick;
		s_d.per_en = (s_d.mode != PSM_DOWN) && tick;
		// Runs on every run-mode tick; the reset-time strap does not gate it here
		s_d.wd_en  = (s_d.mode == PSM_RUN) && tick;
		s_d.pd_out = (s_d.mode == PSM_DOWN);
		s_d.idle   = (s_d.mode == PSM_IDLE);
		// Gated CPU clock leaves its registers untouched
		if (s_d.mode == PSM_IDLE)
		begin
			s_d.ale   = 1'b1;
			s_d.fetch = 1'b1;
			s_d.pins  = (s_d.port_hold & ~port_alt_en)
				| (port_alt_out & port_alt_en);
		end
		else
		begin
			s_d.ale   = cpu_addr_latch;
			s_d.fetch = cpu_program_fetch;
			s_d.pins  = port_out;
		end
		// Arm and start bits read zero
		rd_val = 8'h00;
		rd_val[PSM_BIT_USER_FLAG_A]  = s_q.flag_a;
		rd_val[PSM_BIT_USER_FLAG_B]  = s_q.flag_b;
		rd_val[PSM_BIT_CLOCK_DIVIDE] = s_q.clk_div;
		if (reg_rd && (reg_addr == PSM_OFS_POWER_CONTROL))
			s_d.rdata = rd_val;
		else
			s_d.rdata = 8'h00;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset ends idle; async so any hold length works
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s_q       <= '0;
			s_q.mode  <= PSM_RUN;
			s_q.ale   <= 1'b1;
			s_q.fetch <= 1'b1;
			// Entry stays blocked until the first synchronised sample
			s_q.pin_lvl <= 1'b1;
		end
		else if (clk_en)
			s_q <= s_d;
	end

	assign reg_rdata            = s_q.rdata;
	assign cpu_clk_en           = s_q.cpu_en;
	assign periph_clk_en        = s_q.per_en;
	assign watchdog_run_en      = s_q.wd_en;
	assign watchdog_auto_start  = s_q.wd_auto;
	assign power_down_enter     = s_q.pd_out;
	assign idle_active          = s_q.idle;
	assign slow_active          = slow_now;
	assign addr_latch_strobe    = s_q.ale;
	assign program_fetch_strobe = s_q.fetch;
	assign port_pins            = s_q.pins;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_blocked_no_entry: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && s_q.pin_lvl && s_q.mode == PSM_RUN)
		|=> s_q.mode == PSM_RUN)
		else $error("entry taken while enable pin high");

	chk_same_write_idle: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && wr_pc && reg_wdata[PSM_BIT_HALT_ARM]
		&& s_q.mode == PSM_RUN && !s_q.pd_arm)
		|=> s_q.mode == PSM_RUN)
		else $error("idle entered from combined write");

	chk_idle_wd_stop: assert property (
		@(posedge clk_sys) disable iff (rst)
		idle_active |-> !watchdog_run_en && !cpu_clk_en)
		else $error("watchdog or cpu clocked in idle");

	chk_idle_strobes: assert property (
		@(posedge clk_sys) disable iff (rst)
		idle_active |-> addr_latch_strobe && program_fetch_strobe)
		else $error("strobes low in idle");

	chk_irq_wake: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && idle_active && irq_pending) |=> !idle_active)
		else $error("interrupt did not end idle");

	chk_read_zero: assert property (
		@(posedge clk_sys) disable iff (rst)
		$past(clk_en) |-> (reg_rdata[PSM_BIT_HALT_ARM] == 1'b0
		&& reg_rdata[PSM_BIT_HALT_START] == 1'b0
		&& reg_rdata[PSM_BIT_PD_START] == 1'b0))
		else $error("self-clearing bit read as one");

	chk_pd_priority: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && pd_go && halt_go) |=> s_q.mode == PSM_DOWN)
		else $error("idle chosen over power-down");

	chk_wd_strap_hold: assert property (
		@(posedge clk_sys) disable iff (rst)
		($past(s_q.rst_seen) && s_q.rst_seen) |-> $stable(s_q.wd_auto))
		else $error("watchdog start changed after reset");

	// A tick at the last phase may switch slow-down off, so it is left out
	chk_slow_div: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && slow_now && tick
		&& phase != 4'(PSM_PHASES_PER_MC - 1))
		|=> (!tick) [*7])
		else $error("slow-down not dividing");

	chk_slow_follow: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && tick && phase == 4'(PSM_PHASES_PER_MC - 1))
		|=> slow_now == $past(s_q.clk_div))
		else $error("slow-down did not follow the divide bit");

	chk_pd_start_blocked: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && s_q.pin_lvl) |-> (!pd_go && !halt_go))
		else $error("start accepted while enable pin high");

	chk_arm_single_shot: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && wr_pc && !reg_wdata[PSM_BIT_HALT_ARM]
		&& !reg_wdata[PSM_BIT_PD_ARM])
		|=> (!s_q.halt_arm && !s_q.pd_arm))
		else $error("arm survived a later write");

	chk_periph_idle_clk: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && idle_active && tick) |=> periph_clk_en)
		else $error("peripheral clock lost in idle");

	chk_idle_stays: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && idle_active && !irq_pending) |=> idle_active)
		else $error("idle left without an interrupt");

	chk_pins_idle_hold: assert property (
		@(posedge clk_sys) disable iff (rst)
		(clk_en && idle_active && !irq_pending)
		|=> ((port_pins & ~$past(port_alt_en))
		== (s_q.port_hold & ~$past(port_alt_en))))
		else $error("latched port pins moved in idle");

endmodule

// ===== core/psm_pkg.sv
// Purpose: Shared constants for the power save mode control block
// Assumes: 8-bit register port, 50 MHz system clock
// Notes:   Register offset and bit positions of the power control register
package psm_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] PSM_OFS_POWER_CONTROL = 8'h87;
	localparam logic [7:0] PSM_RST_POWER_CONTROL = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PSM_BIT_HALT_ARM         = 0;
	localparam int PSM_BIT_PD_ARM           = 1;
	localparam int PSM_BIT_USER_FLAG_A      = 2;
	localparam int PSM_BIT_USER_FLAG_B      = 3;
	localparam int PSM_BIT_CLOCK_DIVIDE     = 4;
	localparam int PSM_BIT_HALT_START       = 5;
	localparam int PSM_BIT_PD_START         = 6;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	// One machine cycle is six states of two phases each
	localparam int PSM_PHASES_PER_MC  = 12;
	localparam logic [3:0] PSM_S3P1   = 4'h4;
	localparam int PSM_SLOW_DIVIDE    = 8;
	localparam int PSM_RESET_MC       = 2;

	// ----------------------------------------------------------------
	// Modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PSM_RUN  = 2'b00,
		PSM_IDLE = 2'b01,
		PSM_DOWN = 2'b11
	} psm_mode_t;

endpackage

// ===== core/psm_phase_gen.sv
// Purpose: Phase counter giving the machine-cycle state timing
// Assumes: Counts one phase per enabled clock, divided in slow-down
// Notes:   Slow-down switches at a machine-cycle boundary only
`timescale 1ns/100ps
module psm_phase_gen
	import psm_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       clk_en,
	// Control
	input  wire logic       slow_req,
	// Timing outputs
	output logic            phase_tick,
	output logic [3:0]      phase_idx,
	output logic            slow_active
);

	typedef struct packed
	{
		logic [2:0] div;
		logic [3:0] phase;
		logic       slow;
	} psm_pg_state_t;

	psm_pg_state_t s_q;
	psm_pg_state_t s_d;
	logic          tick;

	always_comb
	begin
		s_d  = s_q;
		tick = (!s_q.slow) || (s_q.div == 3'(PSM_SLOW_DIVIDE - 1));
		if (s_q.slow)
			s_d.div = s_q.div + 3'h1;
		else
			s_d.div = 3'h0;
		if (tick)
		begin
			if (s_q.phase == 4'(PSM_PHASES_PER_MC - 1))
			begin
				s_d.phase = 4'h0;
				// Switching at the cycle edge keeps within two cycles
				s_d.slow  = slow_req;
				s_d.div   = 3'h0;
			end
			else
				s_d.phase = s_q.phase + 4'h1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else if (clk_en)
			s_q <= s_d;
	end

	assign phase_tick  = tick;
	assign phase_idx   = s_q.phase;
	assign slow_active = s_q.slow;

endmodule

// ===== verif/psm_supervisor.sv
// Purpose: Power-fail supervisor driving the enable pin
// Assumes: Pin has a pull-up, so it idles high
// Notes:   Pulls the pin low one edge after a power fail
`timescale 1ns/100ps
module psm_supervisor
(
	// Clock
	input  wire logic clk_sys,
	// Supervisor input and pin
	input  wire logic power_fail,
	output logic      power_save_enable_pin
);
	initial power_save_enable_pin = 1'b1;
	// Released pin falls back to the pull-up level
	always @(posedge clk_sys)
		power_save_enable_pin <= !power_fail;
endmodule

// ===== verif/testbench.sv
// Purpose: Self-checking bench for the power save mode control
// Assumes: Full-rate phases unless slow-down is set
// Notes:   Table rows run with the enable pin high
`timescale 1ns/100ps
module testbench;
	import psm_pkg::*;
	logic       clk_sys, rst, reg_wr, reg_rd, irq_pending, power_fail;
	logic       cpu_addr_latch, cpu_program_fetch, pin;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, port_out, alt_en, alt_out;
	logic [7:0] pins, rv;
	logic       cpu_en, per_en, wd_run, wd_auto, pd, idle, slow, ale, pse;
	logic [23:0] rows [6] = '{24'h870C0C, 24'h870300, 24'h87FF1C,
		24'h86FF00, 24'h871010, 24'h870000};
	int n_mismatch, total_checks, i;
	logic [7:0] nc, np, nw;
	psm_supervisor u_sup (.clk_sys(clk_sys), .power_fail(power_fail),
		.power_save_enable_pin(pin));
	psm_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.power_save_enable_pin(pin), .irq_pending(irq_pending),
		.cpu_addr_latch(cpu_addr_latch),
		.cpu_program_fetch(cpu_program_fetch), .port_out(port_out),
		.port_alt_en(alt_en), .port_alt_out(alt_out),
		.cpu_clk_en(cpu_en), .periph_clk_en(per_en),
		.watchdog_run_en(wd_run), .watchdog_auto_start(wd_auto),
		.power_down_enter(pd), .idle_active(idle), .slow_active(slow),
		.addr_latch_strobe(ale), .program_fetch_strobe(pse),
		.port_pins(pins));
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = !clk_sys;
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Strobe stays up so writes may follow back to back
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
	endtask
	task bus_idle;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		wrap_up();
	end
	initial
	begin
		{reg_wr, reg_rd, irq_pending, power_fail} = '0;
		{reg_addr, reg_wdata, port_out, alt_en, alt_out} = '0;
		{cpu_addr_latch, cpu_program_fetch} = '0;
		n_mismatch = 0;
		total_checks = 0;
		rst = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1 chk(ale, 1'b1);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 chk(wd_auto, 1'b1);
		rd(PSM_OFS_POWER_CONTROL);
		chk(rv, PSM_RST_POWER_CONTROL);
		foreach (rows[i])
		begin
			wr(rows[i][23:16], rows[i][15:8]);
			bus_idle();
			rd(rows[i][23:16]);
			chk(rv, rows[i][7:0]);
			chk({pd, idle}, 2'b00);
		end
		repeat (200) @(posedge clk_sys);
		// ---------------------------------------------------
		// Idle entry and exit, pin low
		// ---------------------------------------------------
		// sequence kept by the stimulus below
		power_fail <= 1'b1;
		repeat (30) @(posedge clk_sys);
		#1 chk(wd_auto, 1'b1);
		// Arm first so the combined write meets a live arm
		wr(PSM_OFS_POWER_CONTROL, 8'h01);
		wr(PSM_OFS_POWER_CONTROL, 8'h21);
		bus_idle();
		repeat (3) @(posedge clk_sys);
		#1 chk(idle, 1'b0);
		port_out <= 8'h5A;
		alt_en   <= 8'h0F;
		wr(PSM_OFS_POWER_CONTROL, 8'h01);
		wr(PSM_OFS_POWER_CONTROL, 8'h20);
		bus_idle();
		chk(idle, 1'b1);
		port_out <= 8'hA5;
		alt_out  <= 8'h0F;
		{nc, np, nw} = '0;
		repeat (24)
		begin
			@(posedge clk_sys);
			#1;
			nc += cpu_en;
			np += per_en;
			nw += wd_run;
		end
		chk(nc, 8'h00);
		chk(np > 0, 1'b1);
		chk(nw, 8'h00);
		chk(pins, 8'h5F);
		chk({ale, pse}, 2'b11);
		irq_pending <= 1'b1;
		for (i = 0; i < 5 && idle !== 1'b0; i++)
			#20;
		chk(idle, 1'b0);
		irq_pending <= 1'b0;
		// ---------------------------------------------------
		// Slow-down on and off
		// ---------------------------------------------------
		wr(PSM_OFS_POWER_CONTROL, 8'h10);
		bus_idle();
		for (i = 0; i < 24 && slow !== 1'b1; i++)
			#20;
		chk(slow, 1'b1);
		// One slow machine cycle gives one clock pulse per phase
		{nc, np} = '0;
		repeat (PSM_PHASES_PER_MC * PSM_SLOW_DIVIDE)
		begin
			@(posedge clk_sys);
			#1;
			nc += cpu_en;
			np += per_en;
		end
		chk(nc, 8'(PSM_PHASES_PER_MC));
		chk(np, 8'(PSM_PHASES_PER_MC));
		wr(PSM_OFS_POWER_CONTROL, 8'h00);
		bus_idle();
		for (i = 0; i < 2 * PSM_PHASES_PER_MC * PSM_SLOW_DIVIDE
			&& slow !== 1'b0; i++)
			#20;
		chk(slow, 1'b0);
		// ---------------------------------------------------
		// Power-down guards and entry
		// ---------------------------------------------------
		power_fail <= 1'b0;
		repeat (30) @(posedge clk_sys);
		wr(PSM_OFS_POWER_CONTROL, 8'h02);
		wr(PSM_OFS_POWER_CONTROL, 8'h40);
		bus_idle();
		repeat (3) @(posedge clk_sys);
		#1 chk(pd, 1'b0);
		power_fail <= 1'b1;
		repeat (30) @(posedge clk_sys);
		// Live arm first, then arm and start together
		wr(PSM_OFS_POWER_CONTROL, 8'h02);
		wr(PSM_OFS_POWER_CONTROL, 8'h42);
		bus_idle();
		repeat (3) @(posedge clk_sys);
		#1 chk(pd, 1'b0);
		wr(PSM_OFS_POWER_CONTROL, 8'h03);
		wr(PSM_OFS_POWER_CONTROL, 8'h60);
		bus_idle();
		chk({pd, idle}, 2'b10);
		// Reset of two machine cycles with the pin low
		rst <= 1'b1;
		repeat (PSM_RESET_MC * PSM_PHASES_PER_MC) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 chk(pd, 1'b0);
		chk(wd_auto, 1'b0);
		wrap_up();
	end
endmodule
